// ==== hw/mcsc_defs.vh ====
// constants for the machine check and check-stop control block
`ifndef MCSC_DEFS_VH
`define MCSC_DEFS_VH

// register offsets (byte addresses, one word each)
`define MCSC_ADDR_W 8
`define MCSC_OFF_MODE 8'h00
`define MCSC_OFF_CR14 8'h04
`define MCSC_OFF_PSW 8'h08
`define MCSC_OFF_CODE 8'h0c
`define MCSC_OFF_STAT 8'h10
`define MCSC_OFF_CAUSE 8'h14

// operating modes, mode register bits 1:0
`define MCSC_MODE_NORMAL 2'h0
`define MCSC_MODE_HARD 2'h1
`define MCSC_MODE_IOSTOP 2'h2
// mode register fields
`define MCSC_MODE_QUIET 2
`define MCSC_MODE_SUP_W 3
`define MCSC_MODE_SUP_E 4
`define MCSC_MODE_W 5
`define MCSC_MODE_RST 5'h00

// control register 14 fields and reset value
`define MCSC_CR14_CSTOP 0
`define MCSC_CR14_E 6
`define MCSC_CR14_W 7
`define MCSC_CR14_RST 32'h0000_0041

// machine check code bit positions
`define MCSC_CODE_W 16
`define MCSC_CODE_SD 0
`define MCSC_CODE_PD 1
`define MCSC_CODE_TD 3
`define MCSC_CODE_CD 4
`define MCSC_CODE_WRN 8
`define MCSC_CODE_DLY 15

// check-stop cause bits
`define MCSC_CAUSE_W 13
`define MCSC_IML_OK 13'h0600

// timing
`define MCSC_CLK_MHZ 50
`define MCSC_SP_TMO_US 1000

`endif

// ==== hw/mcsc_top.v ====
// machine check interruption, operating mode and check-stop control
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "mcsc_defs.vh"
// Function
// [RULE1] enabled instruction error interrupts with processing damage in code bit 1
// [RULE2] enabled unrelated processor failure interrupts with system damage in code bit 0
// [RULE3] normal mode: diskette logout first, then interruption and storage logout
// [RULE4] full recording: every type enabled, each gives interruption and both logouts
// [RULE5] quiet mode: suppressed repressible types give no interruption, no recording
// [RULE6] check-stop halts after diskette logout, with no fixed-area storage logout
// [RULE7] check-stop detection never gated; reset still sets control register 14 bit 0
// [RULE8] lookaside buffer error, multi-bit storage error, access key failure check-stop
// [RULE9] damage while status word bit 13 is zero forces check-stop
// [RULE10] damage during an interruption for earlier damage forces check-stop
// [RULE11] failed code store, failed new status fetch or bad page 0 check-stop
// [RULE12] inconsistent page description after update error forces check-stop
// [RULE13] microcode unable to branch or resume forces check-stop
// [RULE14] support processor communication timeout forces check-stop
// [RULE15] check-stop ignores start and restart; leave by system reset or microcode load (microcode load leaves only if no cause bit but 9 or 10 is set)
// [RULE16] hard-stop mode: any check stops at once, no logouts, no interruption
// [RULE17] logs suppressed in hard-stop are kept and written when normal mode returns
// [RULE18] I/O stop: channel checks stop only after diskette and channel logouts
// [RULE19] after program load or reset, external damage mask on, warning mask off
// [RULE20] program load reset clears status word bit 13; software sets it again
// [RULE21] warning and damage masks sit in register 14, effective only with bit 13
// [RULE22] repressible condition while disabled sets the delayed flag
// [RULE23] console-writable mode register, sampled whenever a check is evaluated
module mcsc_top #(
  parameter [31:0] SP_TMO_CYC = `MCSC_SP_TMO_US * `MCSC_CLK_MHZ
) (
  input wire mclk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire sys_reset,
  input wire initial_program_load,
  input wire microcode_initial_load,
  input wire start_key,
  input wire restart_key,
  input wire err_instr,
  input wire err_system,
  input wire err_timing,
  input wire err_warning,
  input wire err_tlb,
  input wire err_stor_mbit,
  input wire err_access_key,
  input wire err_code_store,
  input wire err_psw_fetch,
  input wire err_page0,
  input wire err_page_desc,
  input wire err_ucode_branch,
  input wire chan_check,
  input wire diskette_log_done,
  input wire storage_logout_done,
  input wire chan_logout_done,
  output reg run,
  output reg check_stop,
  output reg diskette_log_req,
  output reg storage_logout_req,
  output reg chan_logout_req,
  output reg mc_interrupt
);

  localparam ST_IDLE = 3'h0;
  localparam ST_DLOG = 3'h1;
  localparam ST_INTR = 3'h2;
  localparam ST_CHAN = 3'h3;
  localparam ST_STOP = 3'h4;

  // build a machine check code from damage / warning sources
  function [`MCSC_CODE_W-1:0] code_bits;
    input sd;
    input pd;
    input td;
    input wrn;
    begin
      code_bits = {`MCSC_CODE_W{1'b0}};
      code_bits[`MCSC_CODE_SD] = sd;
      code_bits[`MCSC_CODE_PD] = pd;
      code_bits[`MCSC_CODE_TD] = td;
      code_bits[`MCSC_CODE_CD] = td;
      code_bits[`MCSC_CODE_WRN] = wrn;
    end
  endfunction

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`MCSC_MODE_W-1:0] mode_reg;
  reg [31:0] cr14;
  reg psw13;
  reg [`MCSC_CODE_W-1:0] mc_code;
  reg [`MCSC_CODE_W-1:0] pend_code;
  reg [`MCSC_CODE_W-1:0] held_code;
  reg held_valid;
  reg rep_td;
  reg rep_w;
  reg delayed;
  reg stop_after_log;
  reg [`MCSC_CAUSE_W-1:0] cause;
  reg [31:0] tmo_cnt;
  reg chan_dl_seen;
  reg chan_cl_seen;

  // decoded mode, sampled on every evaluation
  wire [1:0] op_mode = mode_reg[1:0]; // RULE23
  wire mode_hard = (op_mode == `MCSC_MODE_HARD);
  wire mode_io = (op_mode == `MCSC_MODE_IOSTOP);
  wire quiet = mode_reg[`MCSC_MODE_QUIET];
  wire exig = err_instr | err_system;
  wire busy_exig = ((state == ST_DLOG) || (state == ST_INTR)) &&
    (pend_code[`MCSC_CODE_SD] || pend_code[`MCSC_CODE_PD]);
  wire waiting = (state == ST_DLOG) || (state == ST_INTR) || (state == ST_CHAN);
  wire tmo_expire = waiting && (tmo_cnt == SP_TMO_CYC - 32'h1); // RULE14
  wire any_check = exig | err_timing | err_warning | err_tlb | err_stor_mbit |
    err_access_key | err_code_store | err_psw_fetch | err_page0 | err_page_desc |
    err_ucode_branch | chan_check;

  // repressible enables: full recording needs only bit 13, quiet uses masks
  wire en_e = psw13 & (~quiet | (cr14[`MCSC_CR14_E] & ~mode_reg[`MCSC_MODE_SUP_E])); // RULE4 RULE21
  wire en_w = psw13 & (~quiet | (cr14[`MCSC_CR14_W] & ~mode_reg[`MCSC_MODE_SUP_W])); // RULE4 RULE21
  // quiet-mode suppression drops the condition entirely
  wire drop_e = quiet & mode_reg[`MCSC_MODE_SUP_E]; // RULE5
  wire drop_w = quiet & mode_reg[`MCSC_MODE_SUP_W]; // RULE5
  wire want_td = (rep_td | (err_timing & ~drop_e));
  wire want_w = (rep_w | (err_warning & ~drop_w));
  wire take_td = want_td & en_e;
  wire take_w = want_w & en_w;

  // check-stop causes detected this cycle, never gated by any control bit
  reg [`MCSC_CAUSE_W-1:0] hit;
  always @* begin
    hit = {`MCSC_CAUSE_W{1'b0}};
    hit[0] = err_tlb; // RULE8 RULE7
    hit[1] = err_stor_mbit; // RULE8
    hit[2] = err_access_key; // RULE8
    hit[3] = exig & ~psw13; // RULE9
    hit[4] = exig & psw13 & busy_exig; // RULE10
    hit[5] = err_code_store; // RULE11
    hit[6] = err_psw_fetch; // RULE11
    hit[7] = err_page0; // RULE11
    hit[8] = err_page_desc; // RULE12
    hit[9] = err_ucode_branch; // RULE13
    hit[10] = tmo_expire; // RULE14
    hit[11] = mode_hard & any_check; // RULE16
    hit[12] = (state == ST_CHAN) && (chan_dl_seen | diskette_log_done) &&
      (chan_cl_seen | chan_logout_done); // RULE18
  end

  wire iml_ok = ((cause & ~`MCSC_IML_OK) == {`MCSC_CAUSE_W{1'b0}});
  wire log_stop = |hit[9:0] & ~hit[10];

  // next state selection
  always @* begin
    next_state = state;
    if (state == ST_STOP) begin
      if (sys_reset || (microcode_initial_load && iml_ok)) begin // RULE15
        next_state = ST_IDLE;
      end
    end else if (hit[10] || hit[11] || hit[12]) begin // RULE14 RULE16 RULE18
      next_state = ST_STOP;
    end else if (log_stop && state != ST_CHAN) begin
      next_state = ST_DLOG; // RULE6
    end else begin
      case (state)
        ST_IDLE: begin
          if (held_valid && !mode_hard) begin
            next_state = ST_DLOG; // RULE17
          end else if ((exig & psw13) | take_td | take_w) begin
            next_state = ST_DLOG; // RULE3
          end else if (chan_check && mode_io) begin
            next_state = ST_CHAN; // RULE18
          end
        end
        ST_DLOG: begin
          if (diskette_log_done) begin
            next_state = stop_after_log ? ST_STOP : ST_INTR; // RULE3 RULE6
          end
        end
        ST_INTR: begin
          if (storage_logout_done) begin
            next_state = ST_IDLE;
          end
        end
        ST_CHAN: next_state = ST_CHAN;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // sequencing, logout requests, interruption and run control
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      stop_after_log <= 1'b0;
      pend_code <= {`MCSC_CODE_W{1'b0}};
      diskette_log_req <= 1'b0;
      storage_logout_req <= 1'b0;
      chan_logout_req <= 1'b0;
      mc_interrupt <= 1'b0;
      check_stop <= 1'b0;
      run <= 1'b0;
      tmo_cnt <= 32'h0;
      chan_dl_seen <= 1'b0;
      chan_cl_seen <= 1'b0;
    end else begin
      state <= next_state;
      mc_interrupt <= 1'b0;
      check_stop <= (next_state == ST_STOP);
      // timeout restarts on every state change
      if (next_state != state || !waiting) begin
        tmo_cnt <= 32'h0;
      end else begin
        tmo_cnt <= tmo_cnt + 32'h1; // RULE14
      end
      // operation runs until check-stop or system reset; start is dead while stopped
      if (next_state == ST_STOP) begin
        run <= 1'b0;
      end else if (sys_reset) begin
        run <= 1'b0;
      end else if ((start_key || restart_key) && state != ST_STOP) begin
        run <= 1'b1; // RULE15
      end
      if (next_state == ST_STOP) begin
        diskette_log_req <= 1'b0; // RULE16
        storage_logout_req <= 1'b0;
        chan_logout_req <= 1'b0;
        stop_after_log <= 1'b0;
      end else if (state != ST_STOP) begin
        case (state)
          ST_IDLE: begin
            if (next_state == ST_DLOG) begin
              diskette_log_req <= 1'b1;
              stop_after_log <= log_stop; // RULE6
              if (held_valid && !mode_hard && !log_stop) begin
                pend_code <= held_code; // RULE17
              end else begin
                pend_code <= code_bits(err_system & psw13, err_instr & psw13,
                  take_td, take_w); // RULE1 RULE2
                pend_code[`MCSC_CODE_DLY] <= delayed;
              end
            end else if (next_state == ST_CHAN) begin
              diskette_log_req <= 1'b1; // RULE18
              chan_logout_req <= 1'b1;
              chan_dl_seen <= 1'b0;
              chan_cl_seen <= 1'b0;
            end
          end
          ST_DLOG: begin
            if (log_stop) begin
              stop_after_log <= 1'b1; // RULE6
            end
            if (diskette_log_done) begin
              diskette_log_req <= 1'b0;
              if (!stop_after_log && !log_stop) begin
                mc_interrupt <= 1'b1; // RULE3
                storage_logout_req <= 1'b1;
              end
            end
          end
          ST_INTR: begin
            if (log_stop) begin
              storage_logout_req <= 1'b0; // RULE6
              diskette_log_req <= 1'b1;
              stop_after_log <= 1'b1;
            end else if (storage_logout_done) begin
              storage_logout_req <= 1'b0;
              pend_code <= {`MCSC_CODE_W{1'b0}};
            end
          end
          ST_CHAN: begin
            if (diskette_log_done) begin
              chan_dl_seen <= 1'b1;
              diskette_log_req <= 1'b0;
            end
            if (chan_logout_done) begin
              chan_cl_seen <= 1'b1;
              chan_logout_req <= 1'b0;
            end
          end
          default: stop_after_log <= 1'b0;
        endcase
      end
    end
  end

  // repressible conditions awaiting enable, delayed flag, hard-stop log
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rep_td <= 1'b0;
      rep_w <= 1'b0;
      delayed <= 1'b0;
      held_code <= {`MCSC_CODE_W{1'b0}};
      held_valid <= 1'b0;
    end else begin
      if (state == ST_IDLE && next_state == ST_DLOG && !held_valid) begin
        rep_td <= want_td & ~take_td;
        rep_w <= want_w & ~take_w;
        delayed <= (want_td & ~take_td) | (want_w & ~take_w); // RULE22
      end else begin
        rep_td <= want_td & ~mode_hard;
        rep_w <= want_w & ~mode_hard;
        if ((err_timing & ~drop_e & ~en_e) | (err_warning & ~drop_w & ~en_w)) begin
          delayed <= 1'b1; // RULE22
        end
      end
      if (hit[11]) begin
        held_code <= held_code | code_bits(err_system, err_instr, err_timing,
          err_warning); // RULE16 RULE17
        held_valid <= 1'b1;
      end else if (state == ST_IDLE && next_state == ST_DLOG && held_valid &&
        !log_stop) begin
        held_code <= {`MCSC_CODE_W{1'b0}}; // RULE17
        held_valid <= 1'b0;
      end
    end
  end

  // software and console registers, reset and program load effects
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= `MCSC_MODE_RST;
      cr14 <= `MCSC_CR14_RST;
      psw13 <= 1'b0;
      mc_code <= {`MCSC_CODE_W{1'b0}};
      cause <= {`MCSC_CAUSE_W{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `MCSC_OFF_MODE) begin
        mode_reg <= reg_wdata[`MCSC_MODE_W-1:0]; // RULE23
      end
      if (sys_reset || initial_program_load) begin
        cr14 <= `MCSC_CR14_RST; // RULE7 RULE19
      end else if (reg_wr && reg_addr == `MCSC_OFF_CR14) begin
        cr14 <= reg_wdata;
      end
      if (initial_program_load) begin
        psw13 <= 1'b0; // RULE20
      end else if (reg_wr && reg_addr == `MCSC_OFF_PSW) begin
        psw13 <= reg_wdata[0];
      end
      // a new code wins over a clearing write
      if (state == ST_DLOG && next_state == ST_INTR) begin
        mc_code <= pend_code; // RULE1 RULE2
      end else if (reg_wr && reg_addr == `MCSC_OFF_CODE) begin
        mc_code <= {`MCSC_CODE_W{1'b0}};
      end
      if (state != ST_STOP) begin
        cause <= cause | hit;
      end else if (next_state == ST_IDLE) begin
        cause <= {`MCSC_CAUSE_W{1'b0}};
      end
    end
  end

  // read data, one cycle after the read strobe
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `MCSC_OFF_MODE: reg_rdata <= {{(32-`MCSC_MODE_W){1'b0}}, mode_reg};
        `MCSC_OFF_CR14: reg_rdata <= cr14;
        `MCSC_OFF_PSW: reg_rdata <= {31'h0, psw13};
        `MCSC_OFF_CODE: reg_rdata <= {16'h0, mc_code};
        `MCSC_OFF_STAT: reg_rdata <= {24'h0, held_valid, delayed, rep_w, rep_td,
          state, check_stop};
        `MCSC_OFF_CAUSE: reg_rdata <= {{(32-`MCSC_CAUSE_W){1'b0}}, cause};
        default: reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule // mcsc_top
`default_nettype wire

// ==== sim/mcsc_top_properties.sv ====
// port assertions for the machine check block
`timescale 1ns/10ps
`default_nettype none
`include "mcsc_defs.vh"
module mcsc_top_properties #(
  parameter [31:0] SP_TMO_CYC = 32'h0000_0014
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic sys_reset,
  input wire logic initial_program_load,
  input wire logic microcode_initial_load,
  input wire logic start_key,
  input wire logic err_instr,
  input wire logic err_system,
  input wire logic diskette_log_done,
  input wire logic run,
  input wire logic check_stop,
  input wire logic diskette_log_req,
  input wire logic storage_logout_req,
  input wire logic chan_logout_req,
  input wire logic mc_interrupt
);
  logic [1:0] mode;
  logic psw13;
  logic [31:0] wcnt;
  logic [2:0] reqs;
  logic [2:0] preq;
  logic idle;
  // shadow of mode and status word bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode <= 2'h0;
      psw13 <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `MCSC_OFF_MODE) mode <= reg_wdata[1:0];
      if (initial_program_load) psw13 <= 1'b0;
      else if (reg_wr && reg_addr == `MCSC_OFF_PSW) psw13 <= reg_wdata[0];
    end
  end
  assign reqs = {chan_logout_req, storage_logout_req, diskette_log_req};
  // cycles one unchanged set of support requests stands unanswered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wcnt <= 32'h0;
      preq <= 3'h0;
    end else begin
      preq <= reqs;
      if (reqs != 3'h0 && reqs == preq && !check_stop) wcnt <= wcnt + 32'h1;
      else wcnt <= 32'h0;
    end
  end
  assign idle = !(diskette_log_req || storage_logout_req || chan_logout_req || check_stop);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_enabled_log: assert property (psw13 && mode == 2'h0 && idle && err_instr |=> diskette_log_req)
    else $error("no diskette log after enabled damage");
  a_log_first: assert property (mc_interrupt |-> $past(diskette_log_done))
    else $error("interruption before diskette log done");
  a_intr_logout: assert property (mc_interrupt |-> storage_logout_req)
    else $error("interruption without storage logout");
  a_stop_nofixed: assert property ($rose(check_stop) |-> !storage_logout_req && !mc_interrupt)
    else $error("storage logout at check-stop");
  a_disabled_dmg: assert property (!psw13 && mode == 2'h0 && idle && err_system |=> !mc_interrupt [*8])
    else $error("interruption with mask bit off");
  a_timeout_bound: assert property (wcnt <= SP_TMO_CYC + 32'h2)
    else $error("support wait outlived the timeout");
  a_stop_holds: assert property (check_stop && !sys_reset && !microcode_initial_load |=> check_stop)
    else $error("check-stop left without reset");
  a_start_ignored: assert property (check_stop && start_key |=> !run)
    else $error("start accepted in check-stop");
  a_reset_exit: assert property (sys_reset |=> !check_stop)
    else $error("system reset did not leave check-stop");
  a_hard_stop: assert property (mode == 2'h1 && idle && err_system |=> check_stop && !diskette_log_req && !mc_interrupt)
    else $error("hard-stop mode did not stop at once");
endmodule // mcsc_top_properties
bind mcsc_top mcsc_top_properties #(.SP_TMO_CYC(SP_TMO_CYC)) mcsc_top_properties_inst (
  .mclk(mclk),
  .resetn(resetn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .sys_reset(sys_reset),
  .initial_program_load(initial_program_load),
  .microcode_initial_load(microcode_initial_load),
  .start_key(start_key),
  .err_instr(err_instr),
  .err_system(err_system),
  .diskette_log_done(diskette_log_done),
  .run(run),
  .check_stop(check_stop),
  .diskette_log_req(diskette_log_req),
  .storage_logout_req(storage_logout_req),
  .chan_logout_req(chan_logout_req),
  .mc_interrupt(mc_interrupt)
);
`default_nettype wire

// ==== sim/mcsc_sp_model.sv ====
// support processor model answering the logout requests
`timescale 1ns/10ps
`default_nettype none
module mcsc_sp_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] delay,
  input wire logic mute,
  input wire logic [2:0] req,
  output logic [2:0] done
);
  logic [3:0] cnt [3];
  logic [2:0] sent;
  // one done pulse per request after delay; mute never answers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done <= 3'h0;
      sent <= 3'h0;
      cnt <= '{default: 4'h0};
    end else begin
      for (int i = 0; i < 3; i++) begin
        done[i] <= 1'b0;
        if (!req[i]) begin
          sent[i] <= 1'b0;
          cnt[i] <= 4'h0;
        end else if (!sent[i] && !mute) begin
          if (cnt[i] >= delay) begin
            done[i] <= 1'b1;
            sent[i] <= 1'b1;
          end else cnt[i] <= cnt[i] + 4'h1;
        end
      end
    end
  end
endmodule // mcsc_sp_model
`default_nettype wire

// ==== sim/mcsc_tb_top.sv ====
// self-checking bench for the machine check block
`timescale 1ns/10ps
`default_nettype none
`include "mcsc_defs.vh"
module mcsc_tb_top;
  localparam int TMO = 20;
  logic mclk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [17:0] pv;
  logic [3:0] delay;
  logic mute;
  wire logic [31:0] reg_rdata;
  wire logic run;
  wire logic check_stop;
  wire logic mc_interrupt;
  wire logic [2:0] req;
  wire logic [2:0] done;
  int err_total;
  int check_count;
  int cb [8] = '{0, 1, 2, 5, 6, 7, 8, 9};
  logic [31:0] dc [4] = '{32'h2, 32'h1, 32'h18, 32'h100};
  mcsc_top #(.SP_TMO_CYC(TMO)) mcsc_top_inst (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sys_reset(pv[13]), .initial_program_load(pv[14]), .microcode_initial_load(pv[15]),
    .start_key(pv[16]), .restart_key(pv[17]), .err_instr(pv[0]), .err_system(pv[1]),
    .err_timing(pv[2]), .err_warning(pv[3]), .err_tlb(pv[4]), .err_stor_mbit(pv[5]),
    .err_access_key(pv[6]), .err_code_store(pv[7]), .err_psw_fetch(pv[8]),
    .err_page0(pv[9]), .err_page_desc(pv[10]), .err_ucode_branch(pv[11]),
    .chan_check(pv[12]), .diskette_log_done(done[0]), .storage_logout_done(done[1]),
    .chan_logout_done(done[2]), .run(run), .check_stop(check_stop),
    .diskette_log_req(req[0]), .storage_logout_req(req[1]), .chan_logout_req(req[2]),
    .mc_interrupt(mc_interrupt)
  );
  mcsc_sp_model mcsc_sp_model_inst (
    .mclk(mclk), .resetn(resetn), .delay(delay), .mute(mute), .req(req), .done(done)
  );
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle bus write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // one-cycle pulse on an event input
  task automatic pulse(input int i);
    @(posedge mclk);
    pv[i] <= 1'b1;
    @(posedge mclk);
    pv[i] <= 1'b0;
  endtask
  // bounded wait: sel 0 interruption, 1 check-stop
  task automatic wait_hi(input int sel, input int n);
    int k;
    k = 0;
    while (k < n && !(sel ? check_stop === 1'b1 : mc_interrupt === 1'b1)) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk(k < n, 32'h1);
  endtask
  task automatic settle;
    repeat (20) @(posedge mclk);
    wr(`MCSC_OFF_CODE, 32'h0);
  endtask
  task automatic t_reset;
    rd(`MCSC_OFF_CR14, `MCSC_CR14_RST);
    rd(`MCSC_OFF_PSW, 32'h0);
    rd(`MCSC_OFF_MODE, 32'h0);
    wr(`MCSC_OFF_STAT, 32'hff);
    rd(`MCSC_OFF_STAT, 32'h0);
    rd(8'h40, 32'h0);
    wr(`MCSC_OFF_CR14, 32'h80);
    wr(`MCSC_OFF_PSW, 32'h1);
    pulse(14);
    rd(`MCSC_OFF_CR14, `MCSC_CR14_RST);
    rd(`MCSC_OFF_PSW, 32'h0);
    wr(`MCSC_OFF_PSW, 32'h1);
    pulse(16);
    #1 chk(run, 32'h1);
  endtask
  task automatic t_damage;
    for (int j = 0; j < 4; j++) begin
      pulse(j);
      wait_hi(0, 40);
      rd(`MCSC_OFF_CODE, dc[j]);
      settle();
    end
    wr(`MCSC_OFF_PSW, 32'h0);
    pulse(2);
    settle();
    rd(`MCSC_OFF_STAT, 32'h50);
    wr(`MCSC_OFF_PSW, 32'h1);
    wait_hi(0, 40);
    rd(`MCSC_OFF_CODE, 32'h8018);
    settle();
  endtask
  task automatic t_quiet;
    logic seen;
    seen = 1'b0;
    wr(`MCSC_OFF_MODE, 32'hc);
    pulse(3);
    for (int k = 0; k < 20; k++) begin
      @(posedge mclk);
      #1;
      seen = seen | (req != 3'h0) | mc_interrupt;
    end
    chk(seen, 32'h0);
    rd(`MCSC_OFF_CODE, 32'h0);
    wr(`MCSC_OFF_MODE, 32'h4);
    pulse(3);
    rd(`MCSC_OFF_STAT, 32'h60);
    wr(`MCSC_OFF_CR14, 32'hc1);
    wait_hi(0, 40);
    rd(`MCSC_OFF_CODE, 32'h8100);
    wr(`MCSC_OFF_MODE, 32'h0);
    settle();
  endtask
  task automatic t_stops;
    for (int j = 0; j < 8; j++) begin
      pulse(j + 4);
      wait_hi(1, 40);
      rd(`MCSC_OFF_CAUSE, 32'h1 << cb[j]);
      pulse(16);
      #1 chk(run, 32'h0);
      pulse(17);
      #1 chk(run, 32'h0);
      pulse(j == 7 ? 15 : 13);
      #1 chk(check_stop, 32'h0);
      pulse(16);
    end
    wr(`MCSC_OFF_PSW, 32'h0);
    pulse(1);
    wait_hi(1, 40);
    rd(`MCSC_OFF_CAUSE, 32'h8);
    pulse(13);
    wr(`MCSC_OFF_PSW, 32'h1);
  endtask
  task automatic t_faults;
    delay <= 4'h8;
    pulse(0);
    wait_hi(0, 40);
    pulse(1);
    wait_hi(1, 60);
    rd(`MCSC_OFF_CAUSE, 32'h10);
    pulse(13);
    delay <= 4'h2;
    mute <= 1'b1;
    pulse(0);
    wait_hi(1, TMO + 10);
    rd(`MCSC_OFF_CAUSE, 32'h400);
    mute <= 1'b0;
    pulse(13);
    settle();
  endtask
  task automatic t_modes;
    wr(`MCSC_OFF_MODE, 32'h1);
    pulse(1);
    wait_hi(1, 3);
    chk(req, 32'h0);
    rd(`MCSC_OFF_CAUSE, 32'h800);
    pulse(13);
    wr(`MCSC_OFF_MODE, 32'h0);
    wait_hi(0, 60);
    rd(`MCSC_OFF_CODE, 32'h1);
    settle();
    wr(`MCSC_OFF_MODE, 32'h2);
    pulse(12);
    wait_hi(1, 60);
    chk(req, 32'h0);
    rd(`MCSC_OFF_CAUSE, 32'h1000);
    pulse(13);
    wr(`MCSC_OFF_MODE, 32'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // reset, then the scenarios
  initial begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pv = 18'h0;
    delay = 4'h2;
    mute = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_damage();
    t_quiet();
    t_stops();
    t_faults();
    t_modes();
    give_verdict();
  end
  // watchdog
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule // mcsc_tb_top
`default_nettype wire
